/* File: design/subr_timer_decoder.sv */
// Purpose: executes subroutine, timer/counter and flag-side-effect opcodes
// Assumes: classic Wishbone slave, one machine cycle per clock
// Notes:   an opcode enters through the instruction register write
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
module subr_timer_decoder #(
  parameter int unsigned STACK_DEPTH = 8,
  parameter int unsigned CNT_W       = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        event_count_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             counter_irq_o
);

  localparam int unsigned SW = $clog2(STACK_DEPTH);
  localparam int unsigned IW = subr_timer_pkg::IP_W;

  subr_timer_pkg::exec_state_e   state_r;
  subr_timer_pkg::counter_mode_e mode_r;
  subr_timer_pkg::stack_slot_s   stack_mem [STACK_DEPTH];
  subr_timer_pkg::field_decode_s dec;
  logic [7:0]       op1_r;
  logic [7:0]       op2_r;
  logic [7:0]       acc_r;
  logic [7:0]       flags_r;
  logic [IW-1:0]    ip_r;
  logic [SW-1:0]    sidx_r;
  logic             bank_r;
  logic             irq_en_r;
  logic             pend_r;
  logic [CNT_W-1:0] count;
  logic             overflow;
  logic             req;
  logic             wr_go;
  logic             idle;
  logic             insn_go;
  logic             first;
  logic             second;
  logic             is_call;
  logic             is_jump;
  logic             is_btest;
  logic             is_exit;
  logic             is_alu;
  logic             two_cycle;
  logic [31:0]      wr_val;
  logic [31:0]      ip_merged;
  logic [7:0]       addend;
  logic             cin;
  logic [8:0]       sum9;
  logic [4:0]       low5;
  logic             lo_fix;
  logic             hi_fix;

  // ==========================================================
  // helpers

  // byte-lane merge for writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // operand field decode shared by register, port, bit and page users
  function automatic subr_timer_pkg::field_decode_s field_dec(input logic [7:0] op);
    subr_timer_pkg::field_decode_s d;
    d              = '0;
    d.reg_valid    = (op[3:0] >= subr_timer_pkg::REG_DIRECT_MIN) ||
                     (op[3:0] <= subr_timer_pkg::REG_IND_MAX);
    d.reg_indirect = (op[3:0] <= subr_timer_pkg::REG_IND_MAX);
    d.reg_num      = d.reg_indirect ? {2'b00, op[0]} : op[2:0];
    d.port_valid   = (op[3:0] == subr_timer_pkg::PORT1_CODE) ||
                     (op[3:0] == subr_timer_pkg::PORT2_CODE) ||
                     (op[3:0] >= subr_timer_pkg::EXP_PORT_MIN);
    d.port_num     = (op[3:0] >= subr_timer_pkg::EXP_PORT_MIN) ? {1'b1, op[1:0]}
                                                               : {1'b0, op[1:0]};
    d.bit_num      = op[7:5];
    d.page         = op[7:5];
    d.page_call    = op[4];
    return d;
  endfunction

  // ==========================================================
  // bus handshake and opcode classes
  assign req      = cyc_i && stb_i;
  assign wr_go    = req && we_i && ack_o; // write lands on the edge ack is sampled
  assign idle     = (state_r == subr_timer_pkg::ST_IDLE);
  assign insn_go  = wr_go && idle && adr_i == subr_timer_pkg::ADR_INSN;
  assign first    = (state_r == subr_timer_pkg::ST_FIRST);
  assign second   = (state_r == subr_timer_pkg::ST_SECOND);
  assign wr_val   = dat_i;
  assign ip_merged = lane_merge({20'h00000, ip_r}, wr_val, sel_i); // a call result cannot be sliced
  assign dec      = field_dec(op1_r);
  assign is_call  = (op1_r & subr_timer_pkg::PAGE_MASK) == subr_timer_pkg::CALL_PAT;
  assign is_jump  = (op1_r & subr_timer_pkg::PAGE_MASK) == subr_timer_pkg::JUMP_PAT;
  assign is_btest = (op1_r & subr_timer_pkg::PAGE_MASK) == subr_timer_pkg::BTEST_PAT;
  assign is_exit  = (op1_r == subr_timer_pkg::OP_EXIT) ||
                    (op1_r == subr_timer_pkg::OP_EXIT_FLAGS);
  assign is_alu   = (op1_r == subr_timer_pkg::OP_SUM_IMM) ||
                    (op1_r == subr_timer_pkg::OP_SUMC_IMM);
  assign two_cycle = is_call || is_jump || is_btest || is_exit || is_alu;

  // ==========================================================
  // adder shared by sum, sum with carry and decimal adjust
  assign lo_fix = (acc_r[3:0] > subr_timer_pkg::BCD_MAX) || flags_r[subr_timer_pkg::PSW_AC];
  assign hi_fix = (acc_r[7:4] > subr_timer_pkg::BCD_MAX) || flags_r[subr_timer_pkg::PSW_CY];
  always_comb begin
    if (op1_r == subr_timer_pkg::OP_DEC_ADJ) begin
      addend = {hi_fix ? subr_timer_pkg::BCD_FIX : 4'h0,
                lo_fix ? subr_timer_pkg::BCD_FIX : 4'h0};
      cin    = 1'b0;
    end else begin
      addend = op2_r;
      cin    = (op1_r == subr_timer_pkg::OP_SUMC_IMM) && flags_r[subr_timer_pkg::PSW_CY];
    end
  end
  assign sum9 = {1'b0, acc_r} + {1'b0, addend} + {8'h00, cin};
  assign low5 = {1'b0, acc_r[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};

  // ==========================================================
  // Wishbone slave: ack one cycle after the request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req && !ack_o;
    end
  end

  // read data registered with ack; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (req && !ack_o) begin
      case (adr_i)
        subr_timer_pkg::ADR_INSN:      dat_o <= {16'h0000, op2_r, op1_r};
        subr_timer_pkg::ADR_ACC:       dat_o <= {24'h000000, acc_r};
        subr_timer_pkg::ADR_IP:        dat_o <= {20'h00000, ip_r};
        subr_timer_pkg::ADR_FLAGS:     dat_o <= {24'h000000, flags_r};
        subr_timer_pkg::ADR_STACK_IDX: dat_o <= {(32-SW)'(0), sidx_r};
        subr_timer_pkg::ADR_STATUS:    dat_o <= {26'h0000000, bank_r, mode_r, irq_en_r,
                                                 pend_r, !idle};
        subr_timer_pkg::ADR_COUNT:     dat_o <= {(32-CNT_W)'(0), count};
        subr_timer_pkg::ADR_DECODE:    dat_o <= {16'h0000, dec};
        default:                       dat_o <= '0;
      endcase
    end
  end

  // ==========================================================
  // execution sequencer: opcode latched, one or two machine cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= subr_timer_pkg::ST_IDLE;
    end else begin
      case (state_r)
        subr_timer_pkg::ST_IDLE:   if (insn_go) begin
          state_r <= subr_timer_pkg::ST_FIRST;
        end
        subr_timer_pkg::ST_FIRST:  state_r <= two_cycle ? subr_timer_pkg::ST_SECOND
                                                        : subr_timer_pkg::ST_IDLE;
        subr_timer_pkg::ST_SECOND: state_r <= subr_timer_pkg::ST_IDLE;
        default:                   state_r <= subr_timer_pkg::ST_IDLE;
      endcase
    end
  end

  // opcode bytes; writes while busy are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op1_r <= subr_timer_pkg::OP_IDLE;
      op2_r <= 8'h00;
    end else if (insn_go) begin
      if (sel_i[0]) begin
        op1_r <= wr_val[7:0];
      end
      if (sel_i[1]) begin
        op2_r <= wr_val[15:8];
      end
    end
  end

  // instruction pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ip_r <= '0;
    end else if (idle && wr_go && adr_i == subr_timer_pkg::ADR_IP) begin
      ip_r <= ip_merged[IW-1:0];
    end else if (first && !two_cycle) begin
      ip_r <= ip_r + 1'b1;
    end else if (second) begin
      if (is_call) begin
        ip_r <= {bank_r, op1_r[7:5], op2_r};
      end else if (is_jump) begin
        ip_r <= {ip_r[IW-1], op1_r[7:5], op2_r};
      end else if (is_btest && acc_r[dec.bit_num]) begin
        ip_r <= {ip_r[IW-1:8], op2_r};
      end else if (is_exit) begin
        ip_r <= stack_mem[sidx_r].ip;
      end else begin
        ip_r <= ip_r + IW'(2);
      end
    end
  end

  // stack index: up on call, down on either exit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sidx_r <= '0;
    end else if (idle && wr_go && adr_i == subr_timer_pkg::ADR_STACK_IDX && sel_i[0]) begin
      sidx_r <= wr_val[SW-1:0];
    end else if (first && is_call) begin
      sidx_r <= sidx_r + 1'b1;
    end else if (first && is_exit) begin
      sidx_r <= sidx_r - 1'b1;
    end
  end

  // stack slots hold return address and upper flag nibble
  always_ff @(posedge clk_i) begin
    if (first && is_call) begin
      stack_mem[sidx_r] <= '{flags: flags_r[7:4], ip: ip_r + IW'(2)};
    end
  end

  // accumulator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= 8'h00;
    end else if (idle && wr_go && adr_i == subr_timer_pkg::ADR_ACC && sel_i[0]) begin
      acc_r <= wr_val[7:0];
    end else if (first && op1_r == subr_timer_pkg::OP_READ_CNT) begin
      acc_r <= count[7:0];
    end else if (first && (is_alu || op1_r == subr_timer_pkg::OP_DEC_ADJ)) begin
      acc_r <= sum9[7:0];
    end
  end

  // flags word: carry and aux carry from the adder, nibble from the stack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= 8'h00;
    end else if (idle && wr_go && adr_i == subr_timer_pkg::ADR_FLAGS && sel_i[0]) begin
      flags_r <= wr_val[7:0];
    end else if (first && (is_alu || op1_r == subr_timer_pkg::OP_DEC_ADJ)) begin
      flags_r[subr_timer_pkg::PSW_CY] <= sum9[8];
      flags_r[subr_timer_pkg::PSW_AC] <= low5[4];
    end else if (second && op1_r == subr_timer_pkg::OP_EXIT_FLAGS) begin
      flags_r[7:4] <= stack_mem[sidx_r].flags;
    end
  end

  // bank flag feeds call target bit 11
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_r <= 1'b0;
    end else if (wr_go && adr_i == subr_timer_pkg::ADR_STATUS && sel_i[0]) begin
      bank_r <= wr_val[subr_timer_pkg::ST_BANK];
    end
  end

  // ==========================================================
  // counter control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= subr_timer_pkg::CNT_STOP;
    end else if (first) begin
      case (op1_r)
        subr_timer_pkg::OP_HALT_CNT:  mode_r <= subr_timer_pkg::CNT_STOP;
        subr_timer_pkg::OP_EVENT_RUN: mode_r <= subr_timer_pkg::CNT_EVENT;
        subr_timer_pkg::OP_TIMER_RUN: mode_r <= subr_timer_pkg::CNT_TIMER;
        default:                      mode_r <= mode_r;
      endcase
    end
  end

  // interrupt enable for counter overflow
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_r <= 1'b0;
    end else if (first && op1_r == subr_timer_pkg::OP_IRQ_EN) begin
      irq_en_r <= 1'b1;
    end else if (first && op1_r == subr_timer_pkg::OP_IRQ_DIS) begin
      irq_en_r <= 1'b0;
    end
  end

  // pending overflow; a new overflow wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= 1'b0;
    end else if (overflow && irq_en_r) begin
      pend_r <= 1'b1;
    end else if (wr_go && adr_i == subr_timer_pkg::ADR_STATUS && sel_i[0] &&
                 wr_val[subr_timer_pkg::ST_PEND]) begin
      pend_r <= 1'b0;
    end
  end

  // request output; disabling masks a request still pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_irq_o <= 1'b0;
    end else begin
      counter_irq_o <= pend_r && irq_en_r;
    end
  end

  counter_unit #(
    .CNT_W (CNT_W)
  ) u_counter (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .mode_i     (mode_r),
    .load_i     (first && op1_r == subr_timer_pkg::OP_LOAD_CNT),
    .load_val_i (CNT_W'(acc_r)),
    .event_i    (event_count_i),
    .count_o    (count),
    .overflow_o (overflow)
  );

endmodule

/* File: design/subr_timer_pkg.sv */
// Purpose: shared constants and types for the subroutine/timer decoder
// Assumes: one machine cycle per clk_i edge
// Notes:   register offsets are byte addresses on a 32-bit bus
package subr_timer_pkg;

  // ==========================================================
  // opcodes and opcode patterns
  localparam logic [7:0] OP_IDLE        = 8'h00;
  localparam logic [7:0] OP_EXIT        = 8'h83;
  localparam logic [7:0] OP_EXIT_FLAGS  = 8'h93;
  localparam logic [7:0] OP_IRQ_EN      = 8'h25;
  localparam logic [7:0] OP_IRQ_DIS     = 8'h35;
  localparam logic [7:0] OP_READ_CNT    = 8'h42;
  localparam logic [7:0] OP_LOAD_CNT    = 8'h62;
  localparam logic [7:0] OP_HALT_CNT    = 8'h65;
  localparam logic [7:0] OP_EVENT_RUN   = 8'h45;
  localparam logic [7:0] OP_TIMER_RUN   = 8'h55;
  localparam logic [7:0] OP_SUM_IMM     = 8'h03;
  localparam logic [7:0] OP_SUMC_IMM    = 8'h13;
  localparam logic [7:0] OP_DEC_ADJ     = 8'h57;
  localparam logic [7:0] PAGE_MASK      = 8'h1F;
  localparam logic [7:0] CALL_PAT       = 8'h14;
  localparam logic [7:0] JUMP_PAT       = 8'h04;
  localparam logic [7:0] BTEST_PAT      = 8'h12;

  // ==========================================================
  // operand field codes
  localparam logic [3:0] REG_DIRECT_MIN = 4'h8;
  localparam logic [3:0] REG_IND_MAX    = 4'h1;
  localparam logic [3:0] PORT1_CODE     = 4'h9;
  localparam logic [3:0] PORT2_CODE     = 4'hA;
  localparam logic [3:0] EXP_PORT_MIN   = 4'hC;
  localparam logic [3:0] BCD_MAX        = 4'h9;
  localparam logic [3:0] BCD_FIX        = 4'h6;

  // ==========================================================
  // flags word bits and timing
  localparam int unsigned PSW_CY        = 7;
  localparam int unsigned PSW_AC        = 6;
  localparam int unsigned TIMER_DIV     = 32;
  localparam int unsigned IP_W          = 12;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADR_INSN       = 8'h00;
  localparam logic [7:0] ADR_ACC        = 8'h04;
  localparam logic [7:0] ADR_IP         = 8'h08;
  localparam logic [7:0] ADR_FLAGS      = 8'h0C;
  localparam logic [7:0] ADR_STACK_IDX  = 8'h10;
  localparam logic [7:0] ADR_STATUS     = 8'h14;
  localparam logic [7:0] ADR_COUNT      = 8'h18;
  localparam logic [7:0] ADR_DECODE     = 8'h1C;
  localparam int unsigned ST_BUSY       = 0;
  localparam int unsigned ST_PEND       = 1;
  localparam int unsigned ST_BANK       = 5;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    CNT_STOP  = 2'b00,
    CNT_TIMER = 2'b01,
    CNT_EVENT = 2'b10
  } counter_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b10
  } exec_state_e;

  typedef struct packed {
    logic [3:0]      flags;
    logic [IP_W-1:0] ip;
  } stack_slot_s;

  typedef struct packed {
    logic       reg_valid;
    logic       reg_indirect;
    logic [2:0] reg_num;
    logic       port_valid;
    logic [2:0] port_num;
    logic [2:0] bit_num;
    logic [2:0] page;
    logic       page_call;
  } field_decode_s;

endpackage

/* File: design/counter_unit.sv */
// Purpose: 8-bit timer / event counter with load and overflow pulse
// Assumes: event input already synchronous to clk_i
// Notes:   prescaler restarts whenever timer mode is left
`timescale 1ns/10ps
module counter_unit #(
  parameter int unsigned CNT_W = 8,
  parameter int unsigned DIV   = subr_timer_pkg::TIMER_DIV
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire subr_timer_pkg::counter_mode_e mode_i,
  input  wire logic                          load_i,
  input  wire logic [CNT_W-1:0]              load_val_i,
  input  wire logic                          event_i,
  output logic      [CNT_W-1:0]              count_o,
  output logic                               overflow_o
);

  localparam int unsigned PW = $clog2(DIV);
  localparam logic [PW-1:0] PRE_LAST = PW'(DIV - 1);

  logic [PW-1:0] pre_r;
  logic          event_q_r;
  logic          step;

  // ==========================================================
  // advance conditions
  assign step = (mode_i == subr_timer_pkg::CNT_TIMER && pre_r == PRE_LAST) ||
                (mode_i == subr_timer_pkg::CNT_EVENT && event_i && !event_q_r);

  // prescaler, one tick per machine cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || mode_i != subr_timer_pkg::CNT_TIMER) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // previous event level for rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_q_r <= 1'b0;
    end else begin
      event_q_r <= event_i;
    end
  end

  // count; a load beats a step in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= '0;
    end else if (load_i) begin
      count_o <= load_val_i;
    end else if (step) begin
      count_o <= count_o + 1'b1;
    end
  end

  // wrap from all ones to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_o <= 1'b0;
    end else begin
      overflow_o <= step && !load_i && (&count_o);
    end
  end

endmodule

/* File: dv/subr_timer_decoder_sva.sv */
// Purpose: port-level assertions for the subroutine/timer decoder
// Assumes: master never writes the opcode register while busy
// Notes:   decode fields judged against the last opcode byte written
`timescale 1ns/10ps
module subr_timer_decoder_sva #(
  parameter int unsigned STACK_DEPTH = 8,
  parameter int unsigned CNT_W       = 8
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0]  sel_i,
  input wire logic        we_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        event_count_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        counter_irq_o
);
  logic [7:0] op_r;
  logic       en_r;
  wire logic  ins_wr = ack_o && we_i && cyc_i && stb_i && sel_i[0]
                       && adr_i == subr_timer_pkg::ADR_INSN;
  wire logic  dec_rd = cyc_i && stb_i && !we_i && !ack_o && adr_i == subr_timer_pkg::ADR_DECODE;
  wire logic [3:0] nib = op_r[3:0];
  // ==========================================================
  // shadow of last opcode and interrupt enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_r <= 8'h00;
      en_r <= 1'b0;
    end else if (ins_wr) begin
      op_r <= dat_i[7:0];
      if (dat_i[7:0] == subr_timer_pkg::OP_IRQ_EN) en_r <= 1'b1;
      if (dat_i[7:0] == subr_timer_pkg::OP_IRQ_DIS) en_r <= 1'b0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // assertions
  ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged one cycle later");
  ack_one_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  dat_hold_a: assert property (!(cyc_i && stb_i && !ack_o) |=> $stable(dat_o))
    else $error("read data moved without a read");
  irq_mask_a: assert property (ins_wr && dat_i[7:0] == subr_timer_pkg::OP_IRQ_DIS
    |-> ##3 !counter_irq_o) else $error("irq still high after disable");
  irq_cause_a: assert property ($rose(counter_irq_o) |-> $past(en_r))
    else $error("irq rose while disabled");
  reg_dec_a: assert property (dec_rd |=> dat_o[15] == (nib >= 4'h8 || nib <= 4'h1)
    && (!dat_o[15] || dat_o[13:11] == (nib[3] ? nib[2:0] : {2'b00, nib[0]})))
    else $error("register field decode wrong");
  port_dec_a: assert property (dec_rd |=> dat_o[10] == (nib == 4'h9 || nib == 4'hA
    || nib >= 4'hC) && (!dat_o[10] || dat_o[9:7] == nib[2:0])) else $error("port decode wrong");
  page_dec_a: assert property (dec_rd && nib == 4'h4 |=> dat_o[3:1] == op_r[7:5]
    && dat_o[0] == op_r[4]) else $error("page decode wrong");
  cover property (ins_wr && dat_i[7:0] == subr_timer_pkg::OP_IRQ_DIS);
  cover property ($rose(counter_irq_o));
  cover property (dec_rd && nib == 4'h4);
endmodule

/* File: dv/prog_mem.sv */
// Purpose: program memory model handing out opcode byte pairs
// Assumes: index settles one cycle before use
// Notes:   byte one is the opcode, byte two the operand
`timescale 1ns/10ps
module prog_mem (
  input  wire logic [3:0]  idx_i,
  output logic      [15:0] word_o
);
  // ==========================================================
  // operand in upper byte, opcode in lower byte
  always_comb begin
    case (idx_i)
      4'h0:    word_o = 16'h0018;
      4'h1:    word_o = 16'h001F;
      4'h2:    word_o = 16'h0010;
      4'h3:    word_o = 16'h0011;
      4'h4:    word_o = 16'h0039;
      4'h5:    word_o = 16'h003A;
      4'h6:    word_o = 16'h003C;
      4'h7:    word_o = 16'h003F;
      4'h8:    word_o = 16'h10F2;
      4'h9:    word_o = 16'h33E4;
      default: word_o = 16'h21B4;
    endcase
  end
endmodule

/* File: dv/subr_timer_decoder_tb.sv */
// Purpose: self-checking bench for the subroutine/timer decoder
// Assumes: ack one cycle after request, busy polled after each opcode until clear
// Notes:   event input and bus driven here; decode-sweep opcodes from prog_mem
`timescale 1ns/10ps
module subr_timer_decoder_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0]  sel_i = 4'h0;
  logic        we_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        event_count_i = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        counter_irq_o;
  logic [3:0]  pidx = 4'h0;
  logic [15:0] pword;
  logic [31:0] q;
  int          compares = 0;
  int          miscompares = 0;
  int          cycles = 0;
  subr_timer_decoder i_subr_timer_decoder (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .event_count_i(event_count_i), .dat_o(dat_o), .ack_o(ack_o), .counter_irq_o(counter_irq_o));
  prog_mem i_prog_mem (.idx_i(pidx), .word_o(pword));
  // ==========================================================
  // clock and hang guard
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // single wishbone cycle; read data lands in q
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] op2);
    bus(subr_timer_pkg::ADR_INSN, 1'b1, {16'h0000, op2, op});
    do bus(subr_timer_pkg::ADR_STATUS, 1'b0, 32'h0); while (q[0] !== 1'b0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  task automatic pulse;
    @(posedge clk_i);
    event_count_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    event_count_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_idle;
    bus(subr_timer_pkg::ADR_ACC, 1'b1, 32'h5A);
    bus(subr_timer_pkg::ADR_IP, 1'b1, 32'h123);
    run(subr_timer_pkg::OP_IDLE, 8'h00);
    rd_chk(subr_timer_pkg::ADR_IP, 32'h124);
    rd_chk(subr_timer_pkg::ADR_ACC, 32'h5A);
    rd_chk(8'h20, 32'h0);
  endtask
  task automatic t_call;
    bus(subr_timer_pkg::ADR_STATUS, 1'b1, 32'h20);
    bus(subr_timer_pkg::ADR_FLAGS, 1'b1, 32'hA0);
    bus(subr_timer_pkg::ADR_STACK_IDX, 1'b1, 32'h0);
    bus(subr_timer_pkg::ADR_IP, 1'b1, 32'h010);
    run(8'h74, 8'h56);
    rd_chk(subr_timer_pkg::ADR_IP, 32'hB56);
    rd_chk(subr_timer_pkg::ADR_STACK_IDX, 32'h1);
    bus(subr_timer_pkg::ADR_FLAGS, 1'b1, 32'h00);
    run(subr_timer_pkg::OP_EXIT_FLAGS, 8'h00);
    rd_chk(subr_timer_pkg::ADR_IP, 32'h012);
    rd_chk(subr_timer_pkg::ADR_FLAGS, 32'hA0);
    rd_chk(subr_timer_pkg::ADR_STACK_IDX, 32'h0);
    run(8'h74, 8'h56);
    bus(subr_timer_pkg::ADR_FLAGS, 1'b1, 32'h50);
    run(subr_timer_pkg::OP_EXIT, 8'h00);
    rd_chk(subr_timer_pkg::ADR_IP, 32'h014);
    rd_chk(subr_timer_pkg::ADR_FLAGS, 32'h50);
  endtask
  // carry pair in flags bits 7:6
  task automatic t_sum(input logic [7:0] op, input logic [7:0] a, input logic [7:0] f,
                       input logic [7:0] imm, input logic [7:0] ea, input logic [1:0] ef);
    bus(subr_timer_pkg::ADR_ACC, 1'b1, {24'h0, a});
    bus(subr_timer_pkg::ADR_FLAGS, 1'b1, {24'h0, f});
    run(op, imm);
    rd_chk(subr_timer_pkg::ADR_ACC, {24'h0, ea});
    bus(subr_timer_pkg::ADR_FLAGS, 1'b0, 32'h0);
    chk({30'h0, q[7:6]}, {30'h0, ef});
  endtask
  task automatic t_counter;
    bus(subr_timer_pkg::ADR_ACC, 1'b1, 32'hFE);
    run(subr_timer_pkg::OP_LOAD_CNT, 8'h00);
    bus(subr_timer_pkg::ADR_ACC, 1'b1, 32'h0);
    run(subr_timer_pkg::OP_READ_CNT, 8'h00);
    rd_chk(subr_timer_pkg::ADR_ACC, 32'hFE);
    run(subr_timer_pkg::OP_IRQ_EN, 8'h00);
    run(subr_timer_pkg::OP_EVENT_RUN, 8'h00);
    repeat (2) pulse();
    rd_chk(subr_timer_pkg::ADR_COUNT, 32'h0);
    bus(subr_timer_pkg::ADR_STATUS, 1'b0, 32'h0);
    chk({31'h0, q[1]}, 32'h1);
    chk({31'h0, counter_irq_o}, 32'h1);
    run(subr_timer_pkg::OP_IRQ_DIS, 8'h00);
    chk({31'h0, counter_irq_o}, 32'h0);
    bus(subr_timer_pkg::ADR_STATUS, 1'b1, 32'h2);
    run(subr_timer_pkg::OP_HALT_CNT, 8'h00);
    pulse();
    rd_chk(subr_timer_pkg::ADR_COUNT, 32'h0);
  endtask
  task automatic t_timer;
    bus(subr_timer_pkg::ADR_ACC, 1'b1, 32'h0);
    run(subr_timer_pkg::OP_LOAD_CNT, 8'h00);
    run(subr_timer_pkg::OP_TIMER_RUN, 8'h00);
    rd_chk(subr_timer_pkg::ADR_COUNT, 32'h0);
    repeat (40) @(posedge clk_i);
    rd_chk(subr_timer_pkg::ADR_COUNT, 32'h1);
    repeat (32) @(posedge clk_i);
    rd_chk(subr_timer_pkg::ADR_COUNT, 32'h2);
    run(subr_timer_pkg::OP_HALT_CNT, 8'h00);
    repeat (40) @(posedge clk_i);
    rd_chk(subr_timer_pkg::ADR_COUNT, 32'h2);
  endtask
  // field decode sweep over the program memory table
  task automatic t_decode;
    logic [3:0] n;
    for (int i = 0; i < 11; i++) begin
      pidx <= i[3:0];
      @(posedge clk_i);
      n = pword[3:0];
      run(pword[7:0], pword[15:8]);
      bus(subr_timer_pkg::ADR_DECODE, 1'b0, 32'h0);
      chk({29'h0, q[15], q[14], q[10]}, {29'h0, n >= 4'h8 || n <= 4'h1, n <= 4'h1,
          n == 4'h9 || n == 4'hA || n >= 4'hC});
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_idle();
    t_call();
    t_sum(subr_timer_pkg::OP_SUM_IMM, 8'h9C, 8'h00, 8'h6A, 8'h06, 2'b11);
    t_sum(subr_timer_pkg::OP_SUM_IMM, 8'h11, 8'hC0, 8'h22, 8'h33, 2'b00);
    t_sum(subr_timer_pkg::OP_SUMC_IMM, 8'h0F, 8'h80, 8'h00, 8'h10, 2'b01);
    t_sum(subr_timer_pkg::OP_DEC_ADJ, 8'hAB, 8'h00, 8'h00, 8'h11, 2'b11);
    t_counter();
    t_timer();
    t_decode();
    report_and_stop();
  end
endmodule
bind subr_timer_decoder subr_timer_decoder_sva #(.STACK_DEPTH(STACK_DEPTH), .CNT_W(CNT_W))
  i_subr_timer_decoder_sva (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
  .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .event_count_i(event_count_i),
  .dat_o(dat_o), .ack_o(ack_o), .counter_irq_o(counter_irq_o));
